/* dv/adc_serial_result_port_tb.sv */
// Purpose: both ends joined, internal mode end driven by the bench
// Assumes: expected words built from result_in at each conversion end
// Notes: busy marks only the moment of capture, never the value
`timescale 1ns/1ps
`default_nettype none
module adc_serial_result_port_tb;
   import asp_pkg::*;
   logic mclk = 1'h0;
   logic sys_rst = 1'h1;
   logic word_ready = 1'h0;
   logic [WORD_W-2:0] result_in = '0;
   logic [WORD_W-2:0] res_q;
   logic [WORD_W-1:0] word_data;
   logic word_valid, busy, int_clk_mode, busy_b, mode_b, busy_q, bq_b;
   logic [WORD_W-1:0] exp_q[$];
   logic [WORD_W-1:0] exp_b[$];
   integer seed = 68865;
   integer miscompares = 0;
   integer num_checks = 0;
   integer pops = 0;
   integer k;
   asp_link link();
   asp_link link_b();
   asp_dev asp_dev_inst (.mclk(mclk), .sys_rst(sys_rst), .link(link), .result_in(result_in),
      .busy(busy), .int_clk_mode(int_clk_mode));
   asp_host #(.EXT_CLK(1'h1)) asp_host_inst (.mclk(mclk), .sys_rst(sys_rst), .link(link),
      .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
   asp_dev asp_dev_inst_b (.mclk(mclk), .sys_rst(sys_rst), .link(link_b),
      .result_in(result_in), .busy(busy_b), .int_clk_mode(mode_b));
   asp_monitor asp_monitor_inst (.mclk(mclk), .sys_rst(sys_rst), .cs_n(link.cs_n),
      .sck(link.sck), .sck_dev_o(link.sck_dev_o), .sck_dev_oe(link.sck_dev_oe),
      .sck_pull(link.sck_pull), .res_oe(link.res_oe),
      .serial_result_out(link.serial_result_out));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] s);
      num_checks++;
      if (e !== s) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic results;
      if (miscompares == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ****
   // Model: one word per finished conversion, flag bit first
   // ****
   always @(posedge mclk) begin
      res_q <= result_in;
      busy_q <= busy;
      bq_b <= busy_b;
      if (busy_q === 1'h1 && busy === 1'h0) exp_q.push_back({1'h0, res_q});
      if (bq_b === 1'h1 && busy_b === 1'h0) exp_b.push_back({1'h0, res_q});
      if (word_valid === 1'h1 && word_ready === 1'h1) begin
         pops++;
         chk("word", exp_q.size() > 0 ? exp_q.pop_front() : 'x, word_data);
      end
   end
   always @(negedge mclk) begin
      if (busy === 1'h1) result_in <= 31'($random(seed));
   end
   // Reads the internal mode end; stop below 32 aborts by select rise
   task automatic rd_b(input integer stop);
      logic [WORD_W-1:0] w;
      logic prev;
      integer n, t, last;
      n = 0;
      w = '0;
      last = 0;
      prev = link_b.sck;
      for (t = 0; t < 3000 && n < stop; t++) begin
         @(negedge mclk);
         if (!prev && link_b.sck === 1'h1) begin
            if (n > 0) chk("period", 32'(SCK_DIV), 32'(t - last));
            w = {w[WORD_W-2:0], link_b.serial_result_out};
            n++;
            last = t;
         end
         prev = link_b.sck;
      end
      chk("bits", 32'(stop), 32'(n));
      if (stop == 32) begin
         chk("int word", exp_b.size() > 0 ? exp_b.pop_front() : 'x, w);
         repeat (6) @(negedge mclk);
         chk("sck held", 32'h1, 32'(link_b.sck));
         chk("busy out", 32'h1, 32'(link_b.serial_result_out));
      end else begin
         void'(exp_b.pop_front());
         link_b.cs_n = 1'h1;
         repeat (6) @(negedge mclk);
         chk("abort busy", 32'h1, 32'(busy_b));
         chk("released", 32'h0, 32'(link_b.res_oe));
      end
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      link_b.cs_n = 1'h1;
      link_b.sck_host_o = 1'h0;
      link_b.sck_host_oe = 1'h1;
      repeat (4) @(negedge mclk);
      sys_rst = 1'h0;
      repeat (8) @(negedge mclk);
      chk("mode ext", 32'h0, 32'(mode_b));
      chk("mode a", 32'h0, 32'(int_clk_mode));
      link_b.sck_host_oe = 1'h0;
      repeat (2) @(negedge mclk);
      link_b.cs_n = 1'h0;
      repeat (8) @(negedge mclk);
      chk("mode int", 32'h1, 32'(mode_b));
      chk("sck low", 32'h0, 32'(link_b.sck));
      chk("flag busy", 32'h1, 32'(link_b.serial_result_out));
      rd_b(32);
      rd_b(32);
      rd_b(5);
      for (k = 0; k < 20000 && exp_q.size() < 17; k++) @(negedge mclk);
      chk("stored", 32'h11, 32'(exp_q.size()));
      repeat (1500) @(negedge mclk);
      chk("held", 32'h11, 32'(exp_q.size()));
      for (k = 0; k < 30000 && pops < 25; k++) begin
         @(negedge mclk);
         word_ready = 1'($random(seed));
      end
      chk("pops", 32'h19, 32'(pops));
      results();
   end
endmodule
`default_nettype wire

/* dv/asp_monitor.sv */
// Purpose: checks on the link between device end and host end
// Assumes: the device end runs in external clock mode
// Notes: helper counters track clock edges, and hi_q the cycles of busy with clock low, while select is low
`timescale 1ns/1ps
`default_nettype none
module asp_monitor (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic sck_dev_o,
   input wire logic sck_dev_oe,
   input wire logic sck_pull,
   input wire logic res_oe,
   input wire logic serial_result_out
);
   logic sck_q;
   logic [5:0] fall_q;
   logic [5:0] rise_q;
   logic [7:0] hi_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ****
   // Edge counters, cleared by select high; hi_q counts busy cycles with clock low
   // ****
   always_ff @(posedge mclk) begin
      sck_q <= sck;
      fall_q <= cs_n ? 6'h00 : fall_q + 6'(sck_q & ~sck);
      rise_q <= cs_n ? 6'h00 : rise_q + 6'(~sck_q & sck);
      hi_q <= (cs_n | sck | ~res_oe | ~serial_result_out) ? 8'h00 : hi_q + 8'h01;
   end
   property p_rel; cs_n [*5] |-> !res_oe; endproperty
   a_rel: assert property (p_rel) else $error("data driven with select high");
   property p_drv; !cs_n [*5] |-> res_oe; endproperty
   a_drv: assert property (p_drv) else $error("flag not driven");
   property p_ext; !sck_dev_oe; endproperty
   a_ext: assert property (p_ext) else $error("clock driven in external mode");
   property p_pull; !(sck_dev_oe && !sck_dev_o) |-> sck_pull; endproperty
   a_pull: assert property (p_pull) else $error("pull-up off");
   property p_chg;
      res_oe && $past(res_oe) && $changed(serial_result_out) |-> !sck;
   endproperty
   a_chg: assert property (p_chg) else $error("data changed with clock high");
   property p_flag; !sck_q && sck && !cs_n && rise_q == 6'h00 |-> !serial_result_out;
   endproperty
   a_flag: assert property (p_flag) else $error("first bit not ready flag");
   property p_end;
      sck_q && !sck && !cs_n && fall_q == 6'h1F |-> ##[2:5] serial_result_out [*6];
   endproperty
   a_end: assert property (p_end) else $error("no busy after last fall");
   property p_conv; hi_q < 8'h64; endproperty
   a_conv: assert property (p_conv) else $error("conversion too long");
   c_end: cover property (sck_q && !sck && fall_q == 6'h1F);
   c_sleep: cover property (!cs_n && res_oe && !serial_result_out && !sck);
   c_busy: cover property (hi_q == 8'h20);
endmodule
`default_nettype wire

/* hdl/asp_dev.sv */
// Purpose: converter end of the serial result port: state sequencing and shift-out
// Assumes: result_in is valid whenever a conversion completes
// Notes: internal clock runs from mclk divided by eight
`timescale 1ns/1ps
`default_nettype none
module asp_dev
   import asp_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   asp_link.dev link,
   input wire logic [WORD_W-2:0] result_in,
   output logic busy,
   output logic int_clk_mode
);
   typedef enum logic [1:0] {ST_CONV, ST_SLEEP, ST_DOUT} asp_state_e;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cs_s1_q <= 1'h1;
         cs_s2_q <= 1'h1;
         cs_s3_q <= 1'h1;
         sck_s1_q <= 1'h1;
         sck_s2_q <= 1'h1;
         sck_s3_q <= 1'h1;
      end else begin
         cs_s1_q <= link.cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         sck_s1_q <= link.sck;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
      end
   end
   wire cs_low = ~cs_s2_q;
   wire cs_fall = cs_s3_q & ~cs_s2_q;
   wire cs_rise = ~cs_s3_q & cs_s2_q;
   wire ext_rise = ~sck_s3_q & sck_s2_q;
   wire ext_fall = sck_s3_q & ~sck_s2_q;

   // ************************************************************
   // State
   // ************************************************************
   asp_state_e st_q, st_d;
   logic mode_int_q, mode_int_d;
   logic [1:0] por_q, por_d;
   logic [7:0] conv_q, conv_d;
   logic [1:0] div_q, div_d;
   logic [5:0] bit_q, bit_d;
   logic [WORD_W-1:0] sr_q, sr_d;
   logic sck_q, sck_d;
   logic sck_oe_q, sck_oe_d;
   logic pull_q, pull_d;
   logic res_q, res_d;
   logic res_oe_q, res_oe_d;
   logic busy_q;

   wire por_busy = por_q != POR_LAST;
   wire tick = div_q == DEV_HALF_LAST;
   wire int_run = mode_int_q & cs_low & ~por_busy & (st_q != ST_CONV);
   wire conv_end = conv_q == CONV_LAST;
   wire [WORD_W-1:0] sr_shift = {sr_q[WORD_W-2:0], 1'h1};

   always_comb begin
      st_d = st_q;
      mode_int_d = mode_int_q;
      por_d = por_q;
      conv_d = conv_q;
      div_d = int_run ? div_q + 2'h1 : 2'h0;
      bit_d = bit_q;
      sr_d = sr_q;
      sck_d = sck_q;
      if (por_busy) begin
         por_d = por_q + 2'h1;
         if (por_q == POR_LAST - 2'h1) begin
            mode_int_d = sck_s2_q;
         end
      end else if (cs_fall) begin
         mode_int_d = sck_s2_q;
         if (sck_s2_q) begin
            sck_d = 1'h0;
         end
      end
      unique case (st_q)
         ST_CONV: begin
            conv_d = conv_q + 8'h01;
            if (conv_end) begin
               st_d = ST_SLEEP;
               conv_d = 8'h00;
               sr_d = {1'h0, result_in};
               if (mode_int_q & cs_low) begin
                  sck_d = 1'h0;
               end
            end
         end
         ST_SLEEP: begin
            if (!mode_int_q && cs_low && ext_rise) begin
               st_d = ST_DOUT;
               bit_d = 6'h00;
            end else if (int_run && tick) begin
               st_d = ST_DOUT;
               sck_d = 1'h1;
               bit_d = 6'h01;
            end
         end
         ST_DOUT: begin
            if (cs_rise) begin
               st_d = ST_CONV;
               sck_d = 1'h1;
            end else if (!mode_int_q && ext_fall) begin
               sr_d = sr_shift;
               bit_d = bit_q + 6'h01;
               if (bit_q == BIT_LAST) begin
                  st_d = ST_CONV;
               end
            end else if (int_run && tick && bit_q == BIT_ALL) begin
               // Last bit stands half a period past the 32nd rise so it can be latched
               st_d = ST_CONV;
            end else if (int_run && tick) begin
               sck_d = ~sck_q;
               if (sck_q) begin
                  sr_d = sr_shift;
               end else begin
                  bit_d = bit_q + 6'h01;
               end
            end
         end
      endcase
   end

   // ************************************************************
   // Pin drive, computed from next state so the pins stay registered
   // ************************************************************
   wire dout_next = st_d == ST_DOUT;
   assign res_d = dout_next ? sr_d[WORD_W-1] : (st_d == ST_CONV);
   assign res_oe_d = ~cs_s2_q;
   assign sck_oe_d = mode_int_d & ~cs_s2_q & ~por_busy;
   // Pull-up drops only while the device holds the pin low
   assign pull_d = ~(sck_oe_d & ~sck_d);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= ST_CONV;
         mode_int_q <= 1'h1;
         por_q <= 2'h0;
         conv_q <= 8'h00;
         div_q <= 2'h0;
         bit_q <= 6'h00;
         sr_q <= '0;
         sck_q <= SCK_RST;
         sck_oe_q <= 1'h0;
         pull_q <= 1'h1;
         res_q <= 1'h1;
         res_oe_q <= 1'h0;
         busy_q <= 1'h1;
      end else begin
         st_q <= st_d;
         mode_int_q <= mode_int_d;
         por_q <= por_d;
         conv_q <= st_d == ST_CONV ? conv_d : 8'h00;
         div_q <= div_d;
         bit_q <= bit_d;
         sr_q <= sr_d;
         sck_q <= sck_d;
         sck_oe_q <= sck_oe_d;
         pull_q <= pull_d;
         res_q <= res_d;
         res_oe_q <= res_oe_d;
         busy_q <= st_d == ST_CONV;
      end
   end

   assign link.sck_dev_o = sck_q;
   assign link.sck_dev_oe = sck_oe_q;
   assign link.sck_pull = pull_q;
   assign link.res_o = res_q;
   assign link.res_oe = res_oe_q;
   assign busy = busy_q;
   assign int_clk_mode = mode_int_q;
endmodule
`default_nettype wire

/* hdl/asp_fifo.sv */
// Purpose: word buffer between the host's receiver and its user
// Assumes: depth is a power of two
// Notes: in_ready low stalls the receiver before it starts a read
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign in_ready = cnt_q != (AW+1)'(D);
   assign out_valid = cnt_q != '0;
   assign out_data = mem[rd_q];
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_q + AW'(push);
         rd_q <= rd_q + AW'(pop);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

/* hdl/asp_host.sv */
// Purpose: host end: reads 32-bit words from the converter into a FIFO
// Assumes: EXT_CLK fixes the clock mode from reset onward
// Notes: a read starts only while the FIFO has room
`timescale 1ns/1ps
`default_nettype none
module asp_host
   import asp_pkg::*;
#(
   parameter logic EXT_CLK = 1'h1
) (
   input wire logic mclk,
   input wire logic sys_rst,
   asp_link.host link,
   output logic word_valid,
   input wire logic word_ready,
   output logic [WORD_W-1:0] word_data
);
   typedef enum logic [1:0] {H_IDLE, H_WAIT, H_CLK, H_PUSH} asp_host_state_e;

   // ************************************************************
   // Receive sequencing
   // ************************************************************
   asp_host_state_e st_q;
   logic cs_q;
   logic sck_q;
   logic sck_prev_q;
   logic [2:0] cnt_q;
   logic [5:0] bit_q;
   logic [WORD_W-1:0] sr_q;
   logic in_ready;
   wire flag_low = ~link.serial_result_out;
   wire int_rise = ~sck_prev_q & link.sck;
   wire ext_tick = cnt_q == HOST_HALF_LAST;
   wire all_bits = bit_q == BIT_ALL;
   wire [WORD_W-1:0] sr_in = {sr_q[WORD_W-2:0], link.serial_result_out};

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= H_IDLE;
         cs_q <= CS_N_RST;
         sck_q <= 1'h0;
         sck_prev_q <= 1'h0;
         cnt_q <= 3'h0;
         bit_q <= 6'h00;
         sr_q <= '0;
      end else begin
         sck_prev_q <= link.sck;
         unique case (st_q)
            H_IDLE: begin
               cnt_q <= 3'h0;
               bit_q <= 6'h00;
               if (in_ready) begin
                  cs_q <= 1'h0;
                  st_q <= H_WAIT;
               end
            end
            H_WAIT: begin
               if (cnt_q != HOST_SETTLE) begin
                  cnt_q <= cnt_q + 3'h1;
               end else if (flag_low) begin
                  cnt_q <= 3'h0;
                  st_q <= H_CLK;
               end
            end
            H_CLK: begin
               if (EXT_CLK) begin
                  cnt_q <= cnt_q + 3'h1;
                  if (ext_tick) begin
                     sck_q <= ~sck_q;
                     if (!sck_q) begin
                        sr_q <= sr_in;
                        bit_q <= bit_q + 6'h01;
                     end else if (all_bits) begin
                        st_q <= H_PUSH;
                     end
                  end
               end else if (all_bits) begin
                  st_q <= H_PUSH;
               end else if (int_rise) begin
                  sr_q <= sr_in;
                  bit_q <= bit_q + 6'h01;
               end
            end
            H_PUSH: begin
               // In external clock mode select rises a cycle after the last fall, so the device ends the word itself
               cs_q <= 1'h1;
               st_q <= H_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Buffer, its room gates the next read
   // ************************************************************
   asp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .in_valid(st_q == H_PUSH),
      .in_ready(in_ready),
      .in_data(sr_q),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word_data)
   );

   assign link.cs_n = cs_q;
   assign link.sck_host_o = sck_q;
   assign link.sck_host_oe = EXT_CLK;
endmodule
`default_nettype wire

/* hdl/asp_link.sv */
// Purpose: wires between the converter port and its host
// Assumes: weak pull-up and undriven data line resolve as below
// Notes: an undriven clock pin without pull-up reads low
`timescale 1ns/1ps
`default_nettype none
interface asp_link;
   logic cs_n;
   logic sck_dev_o;
   logic sck_dev_oe;
   logic sck_pull;
   logic sck_host_o;
   logic sck_host_oe;
   logic res_o;
   logic res_oe;
   wire sck;
   wire serial_result_out;
   assign sck = sck_dev_oe ? sck_dev_o : (sck_host_oe ? sck_host_o : sck_pull);
   assign serial_result_out = res_oe ? res_o : 1'h1;
   modport dev (input cs_n, input sck, output sck_dev_o, output sck_dev_oe,
      output sck_pull, output res_o, output res_oe);
   modport host (output cs_n, output sck_host_o, output sck_host_oe,
      input sck, input serial_result_out);
endinterface
`default_nettype wire

/* hdl/asp_pkg.sv */
// Purpose: shared constants of the serial result port, device end and host end
// Assumes: one 40 MHz clock for both ends
// Notes: conversion time is a stand-in for the analog converter, kept short
package asp_pkg;
   // ************************************************************
   // Word and clocking
   // ************************************************************
   localparam int WORD_W = 32;
   localparam int CLK_NS = 25;
   localparam int SCK_DIV = 8;
   localparam int DEV_HALF = SCK_DIV / 2;
   localparam logic [1:0] DEV_HALF_LAST = 2'(DEV_HALF - 1);
   localparam logic [5:0] BIT_LAST = 6'(WORD_W - 1);
   localparam logic [5:0] BIT_ALL = 6'(WORD_W);
   // ************************************************************
   // Timing counts
   // ************************************************************
   localparam int CONV_NS = 2000;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] CONV_LAST = 8'(CONV_CYC - 1);
   localparam logic [1:0] POR_LAST = 2'h3;
   localparam int HOST_HALF = 8;
   localparam logic [2:0] HOST_HALF_LAST = 3'(HOST_HALF - 1);
   localparam logic [2:0] HOST_SETTLE = 3'h6;
   // ************************************************************
   // Reset values and buffering
   // ************************************************************
   localparam logic SCK_RST = 1'h1;
   localparam logic CS_N_RST = 1'h1;
   localparam int FIFO_DEPTH = 16;
endpackage
